// ### rtl/ufs_top.sv
// Function
// [R1] Any mode: writing transmit holding register while transmit FIFO full sets write error.
// [R2] LIN master: writing param1_low during active header sets write error.
// [R3] LIN slave: tx write with param2 zero or over param2 since Break errors.
// [R4] Address detect: param1_low rewritten before shifter took it sets write error.
// [R5] Stop timing bit picks rx interrupt at stop end or mid first stop.
// [R6] tx_buffer_empty reads empty; writing 1 flushes transmit buffer and shifter.
// [R7] tx_buffer_full reflects transmit full; hardware only.
// [R8] rx_line_idle is 1 when receiver idle, 0 while receiving anything.
// [R9] sw_flow_tx_allowed shows flow control permission; hardware only.
// [R10] rx_buffer_empty reads empty; writing 1 flushes receive buffer.
// [R11] rx_buffer_full reflects receive full; hardware only.
// [R12] Reset: empties, idle, flow set; error, timing, fulls cleared.
// [R13] Software writes whole register with 0 at tx empty, not bit-set.
// [R14] Writing 0 to empty bits does nothing; hardware-only bits ignore writes.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ufs_top
    import ufs_pkg::*;
#(
    parameter int P2_W = 8
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    // AHB-Lite slave
    input  wire logic         i_hsel,
    input  wire logic [7:0]   i_haddr,
    input  wire logic [1:0]   i_htrans,
    input  wire logic         i_hwrite,
    input  wire logic [2:0]   i_hsize,
    input  wire logic [31:0]  i_hwdata,
    input  wire logic         i_hready,
    output logic [31:0]       o_hrdata,
    output logic              o_hreadyout,
    output logic              o_hresp,
    // Serial engine state and events
    input  wire ufs_fifo_type i_fifo,
    input  wire ufs_evt_type  i_evt,
    // Controls to serial engine
    output logic              o_tx_flush,
    output logic              o_rx_flush,
    output logic              o_rx_int_flag,
    output ufs_mode_type      o_mode,
    output logic [1:0]        o_stop_sel,
    output logic [P2_W-1:0]   o_param2,
    // Interrupt
    output logic              o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture

    logic       wr_pend_r;
    logic       rd_pend_r;
    logic [7:0] addr_r;
    logic       wr_stb;
    logic       addr_ok;

    // Transfer size is not checked: every register is one whole word
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end else if (i_hready) begin
            wr_pend_r <= i_hsel && i_htrans[1] && i_hwrite;
            rd_pend_r <= i_hsel && i_htrans[1] && !i_hwrite;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            addr_r <= 8'h00;
        end else if (i_hready) begin
            addr_r <= i_haddr;
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign wr_stb      = wr_pend_r;
    assign addr_ok     = (addr_r == UFS_ADDR_STATUS) || (addr_r == UFS_ADDR_CTRL)
                      || (addr_r == UFS_ADDR_IRQST) || (addr_r == UFS_ADDR_IRQMSK);

    ////////////////////////////////////////////////////////////////////////////
    // Write strobes, one per register

    logic ctrl_wr;
    logic irqst_wr;
    logic irqmsk_wr;

    assign ctrl_wr   = wr_stb && (addr_r == UFS_ADDR_CTRL);
    assign irqst_wr  = wr_stb && (addr_r == UFS_ADDR_IRQST);
    assign irqmsk_wr = wr_stb && (addr_r == UFS_ADDR_IRQMSK);

    ////////////////////////////////////////////////////////////////////////////
    // Control register: mode, stop select, param2

    logic [1:0]      mode_r;
    logic [1:0]      stop_r;
    logic [P2_W-1:0] p2_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode_r <= 2'h0;
        end else if (ctrl_wr) begin
            mode_r <= i_hwdata[UFS_C_MODE_LO +: 2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            stop_r <= 2'h0;
        end else if (ctrl_wr) begin
            stop_r <= i_hwdata[UFS_C_STOP_LO +: 2];
        end
    end

    // Changing param2 mid-frame applies to the next byte written
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            p2_r <= '0;
        end else if (ctrl_wr) begin
            p2_r <= i_hwdata[UFS_C_PARAM_LO +: P2_W];
        end
    end

    assign o_mode     = ufs_mode_type'(mode_r);
    assign o_stop_sel = stop_r;
    assign o_param2   = p2_r;

    ////////////////////////////////////////////////////////////////////////////
    // Status register

    logic werr_r;
    logic stptim_r;
    logic werr_evt;
    logic st_wr;

    assign st_wr = wr_stb && addr_r == UFS_ADDR_STATUS;

    ufs_werr #(
        .CNT_W (P2_W)
    ) u_werr (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_mode    (o_mode),
        .i_param2  (p2_r),
        .i_evt     (i_evt),
        .i_tx_full (i_fifo.tx_full),
        .o_err_evt (werr_evt)
    );

    // Set beats a simultaneous software clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            werr_r <= UFS_STATUS_RST[UFS_B_TXWERR];                          // [R12]
        end else if (werr_evt) begin
            werr_r <= 1'b1;                                                  // [R1]
        end else if (st_wr && !i_hwdata[UFS_B_TXWERR]) begin
            werr_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            stptim_r <= UFS_STATUS_RST[UFS_B_STPTIM];                        // [R12]
        end else if (st_wr) begin
            stptim_r <= i_hwdata[UFS_B_STPTIM];
        end
    end

    // Flush only on a written 1; writes of 0 do nothing
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_tx_flush <= 1'b0;
        end else begin
            o_tx_flush <= st_wr && i_hwdata[UFS_B_TX_BUFFER_EMPTY];                     // [R6] [R14]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rx_flush <= 1'b0;
        end else begin
            o_rx_flush <= st_wr && i_hwdata[UFS_B_RX_BUFFER_EMPTY];                     // [R10] [R14]
        end
    end

    // Hardware-owned bits, one cycle behind the engine
    logic tx_buffer_empty_r;
    logic tx_buffer_full_r;
    logic rx_line_idle_r;
    logic swflow_r;
    logic rx_buffer_empty_r;
    logic rx_buffer_full_r;

    // A flush shows empty at once, so software never reads stale fill
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tx_buffer_empty_r <= UFS_STATUS_RST[UFS_B_TX_BUFFER_EMPTY];                            // [R12]
        end else begin
            tx_buffer_empty_r <= i_fifo.tx_empty || o_tx_flush;                         // [R6]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tx_buffer_full_r <= UFS_STATUS_RST[UFS_B_TX_BUFFER_FULL];                            // [R12]
        end else begin
            tx_buffer_full_r <= i_fifo.tx_full && !o_tx_flush;                         // [R7]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rx_line_idle_r <= UFS_STATUS_RST[UFS_B_RX_LINE_IDLE];                          // [R12]
        end else begin
            rx_line_idle_r <= !i_fifo.rx_busy;                                      // [R8]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            swflow_r <= UFS_STATUS_RST[UFS_B_SWFLOW];                        // [R12]
        end else begin
            swflow_r <= i_fifo.flow_ok;                                      // [R9]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rx_buffer_empty_r <= UFS_STATUS_RST[UFS_B_RX_BUFFER_EMPTY];                            // [R12]
        end else begin
            rx_buffer_empty_r <= i_fifo.rx_empty || o_rx_flush;                         // [R10]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rx_buffer_full_r <= UFS_STATUS_RST[UFS_B_RX_BUFFER_FULL];                            // [R12]
        end else begin
            rx_buffer_full_r <= i_fifo.rx_full && !o_rx_flush;                         // [R11]
        end
    end

    logic [7:0] status;

    // Software write to hardware-only bits never lands here
    always_comb begin
        status               = 8'h00;                                        // [R14]
        status[UFS_B_TXWERR] = werr_r;
        status[UFS_B_STPTIM] = stptim_r;
        status[UFS_B_TX_BUFFER_EMPTY]   = tx_buffer_empty_r;
        status[UFS_B_TX_BUFFER_FULL]   = tx_buffer_full_r;
        status[UFS_B_RX_LINE_IDLE]  = rx_line_idle_r;
        status[UFS_B_SWFLOW] = swflow_r;
        status[UFS_B_RX_BUFFER_EMPTY]   = rx_buffer_empty_r;
        status[UFS_B_RX_BUFFER_FULL]   = rx_buffer_full_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive interrupt timing

    // With the timing bit set, stop select codes other than the first-stop code use the last stop end
    logic rx_evt;

    always_comb begin
        if (!stptim_r) begin
            rx_evt = i_evt.stop_mid;                                         // [R5]
        end else if (stop_r == UFS_STOP_FIRST) begin
            rx_evt = i_evt.stop_first_end;                                   // [R5]
        end else begin
            rx_evt = i_evt.stop_last_end;                                    // [R5]
        end
    end

    // Registered so the engine sees a clean one-cycle pulse
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rx_int_flag <= 1'b0;
        end else begin
            o_rx_int_flag <= rx_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    logic [2:0] irq_st_r;
    logic [2:0] irq_msk_r;
    logic [2:0] irq_set;

    always_comb begin
        irq_set             = 3'h0;
        irq_set[UFS_I_WERR] = werr_evt;                                      // [R1]
        irq_set[UFS_I_RX]   = rx_evt;                                        // [R5]
        irq_set[UFS_I_W]    = i_evt.tx_wr;
    end

    // Write-one-to-clear; new event wins
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_st_r <= 3'h0;
        end else if (irqst_wr) begin
            irq_st_r <= (irq_st_r & ~i_hwdata[2:0]) | irq_set;
        end else begin
            irq_st_r <= irq_st_r | irq_set;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_msk_r <= 3'h0;
        end else if (irqmsk_wr) begin
            irq_msk_r <= i_hwdata[2:0];
        end
    end

    // Mask gates only the output; masked events still latch in status
    assign o_irq = |(irq_st_r & irq_msk_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        case (addr_r)
            UFS_ADDR_STATUS: rdata[7:0] = status;
            UFS_ADDR_CTRL: begin
                rdata[UFS_C_MODE_LO +: 2]     = mode_r;
                rdata[UFS_C_STOP_LO +: 2]     = stop_r;
                rdata[UFS_C_PARAM_LO +: P2_W] = p2_r;
            end
            UFS_ADDR_IRQST:  rdata[2:0] = irq_st_r;
            UFS_ADDR_IRQMSK: rdata[2:0] = irq_msk_r;
            default:         rdata = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave: data phase answered combinationally from registers
    // Unmapped reads return zero with an OKAY answer
    assign o_hrdata = (rd_pend_r && addr_ok) ? rdata : 32'h0000_0000;

endmodule

// ### rtl/ufs_pkg.sv
package ufs_pkg;

    // Register byte addresses
    localparam logic [7:0] UFS_ADDR_STATUS = 8'h00;
    localparam logic [7:0] UFS_ADDR_CTRL   = 8'h04;
    localparam logic [7:0] UFS_ADDR_IRQST  = 8'h08;
    localparam logic [7:0] UFS_ADDR_IRQMSK = 8'h0c;

    // Field positions of serial_fifo_status
    localparam int UFS_B_TXWERR = 7;
    localparam int UFS_B_STPTIM = 6;
    localparam int UFS_B_TX_BUFFER_EMPTY   = 5;
    localparam int UFS_B_TX_BUFFER_FULL   = 4;
    localparam int UFS_B_RX_LINE_IDLE  = 3;
    localparam int UFS_B_SWFLOW = 2;
    localparam int UFS_B_RX_BUFFER_EMPTY   = 1;
    localparam int UFS_B_RX_BUFFER_FULL   = 0;

    // Reset value of serial_fifo_status
    localparam logic [7:0] UFS_STATUS_RST = 8'h2e;

    // Interrupt status bits
    localparam int UFS_I_WERR = 0;
    localparam int UFS_I_RX   = 1;
    localparam int UFS_I_W    = 2;

    // Control register field positions
    localparam int UFS_C_MODE_LO  = 0;
    localparam int UFS_C_STOP_LO  = 2;
    localparam int UFS_C_PARAM_LO = 8;

    // Stop select code for one-and-half style "first stop" case
    localparam logic [1:0] UFS_STOP_FIRST = 2'h3;

    // Cycle counts
    localparam int UFS_STOP_HALF_CYC = 1;

    typedef enum logic [1:0] {
        UFS_MODE_NORMAL,
        UFS_MODE_LIN_MASTER,
        UFS_MODE_LIN_SLAVE,
        UFS_MODE_ADDR_DET
    } ufs_mode_type;

    // Events from the serial engine
    typedef struct packed {
        logic tx_wr;        // Write to tx_holding_reg
        logic p1l_wr;       // Write to param1_low
        logic brk;          // Break detected
        logic p1l_moved;    // param1_low taken by shifter
        logic hdr_active;   // LIN master header in progress
        logic stop_mid;     // Middle of first stop bit
        logic stop_first_end;
        logic stop_last_end;
    } ufs_evt_type;

    typedef struct packed {
        logic tx_empty;
        logic tx_full;
        logic rx_empty;
        logic rx_full;
        logic rx_busy;
        logic flow_ok;
    } ufs_fifo_type;

endpackage

// ### rtl/ufs_werr.sv
`timescale 1ns/1ps
module ufs_werr
    import ufs_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    // Mode and events
    input  wire ufs_mode_type     i_mode,
    input  wire logic [CNT_W-1:0] i_param2,
    input  wire ufs_evt_type      i_evt,
    input  wire logic             i_tx_full,
    // Result
    output logic                  o_err_evt
);

    logic [CNT_W:0] slave_cnt_r;
    logic           p1l_pend_r;
    logic           err_any;

    // Bytes written since last Break, saturating
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_evt.brk) begin
            slave_cnt_r <= '0;
        end else if (i_evt.tx_wr && !(&slave_cnt_r)) begin
            slave_cnt_r <= slave_cnt_r + 1'b1;
        end
    end

    // Previous param1_low still waiting for the shifter
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            p1l_pend_r <= 1'b0;
        end else if (i_evt.p1l_wr) begin
            p1l_pend_r <= 1'b1;
        end else if (i_evt.p1l_moved) begin
            p1l_pend_r <= 1'b0;
        end
    end

    always_comb begin
        err_any = i_evt.tx_wr && i_tx_full;                                  // [R1]
        case (i_mode)
            UFS_MODE_LIN_MASTER: begin
                err_any = err_any || (i_evt.p1l_wr && i_evt.hdr_active);     // [R2]
            end
            UFS_MODE_LIN_SLAVE: begin
                err_any = err_any || (i_evt.tx_wr && ((i_param2 == '0)        // [R3]
                          || (slave_cnt_r >= {1'b0, i_param2})));            // [R3]
            end
            UFS_MODE_ADDR_DET: begin
                err_any = err_any || (i_evt.p1l_wr && p1l_pend_r);           // [R4]
            end
            default: begin
                err_any = err_any;
            end
        endcase
    end

    assign o_err_evt = err_any;

endmodule

// ### tb/ufs_chk.sv
`timescale 1ns/1ps
module ufs_chk
    import ufs_pkg::*;
(
    // Clock, reset and bus
    input wire logic         i_clk,
    input wire logic         i_sys_rst,
    input wire logic         i_hsel,
    input wire logic [7:0]   i_haddr,
    input wire logic [1:0]   i_htrans,
    input wire logic         i_hwrite,
    input wire logic [31:0]  i_hwdata,
    input wire logic         i_hready,
    input wire logic [31:0]  o_hrdata,
    input wire logic         o_hreadyout,
    input wire logic         o_hresp,
    // Engine side
    input wire ufs_fifo_type i_fifo,
    input wire ufs_evt_type  i_evt,
    input wire logic         o_tx_flush,
    input wire logic         o_rx_flush,
    input wire logic         o_rx_int_flag,
    input wire ufs_mode_type o_mode,
    input wire logic [1:0]   o_stop_sel,
    input wire logic         o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////
    logic take;
    logic rd_r;
    logic wr_r;
    logic tim_r;
    logic werr_r;
    logic txf;
    logic rxf;
    logic sel;
    assign take = i_hsel && i_hready && i_htrans[1] && i_haddr == UFS_ADDR_STATUS;
    assign txf  = wr_r && i_hwdata[5];
    assign rxf  = wr_r && i_hwdata[1];
    // Stop event chosen by timing bit and stop select
    assign sel  = tim_r ? (o_stop_sel == UFS_STOP_FIRST ? i_evt.stop_first_end
                  : i_evt.stop_last_end) : i_evt.stop_mid;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_r   <= 1'b0;
            wr_r   <= 1'b0;
            tim_r  <= 1'b0;
            werr_r <= 1'b0;
        end else begin
            rd_r <= take && !i_hwrite;
            wr_r <= take && i_hwrite;
            if (wr_r) tim_r <= i_hwdata[6];
            // Set wins over a software clear
            if (i_evt.tx_wr && i_fifo.tx_full) werr_r <= 1'b1;
            else if (wr_r && !i_hwdata[7]) werr_r <= 1'b0;
        end
    end
    ////////////////////////////////////////
    AST_BUS: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready or not okay");
    AST_TX_BUFFER_EMPTY: assert property (rd_r |-> o_hrdata[5] == $past(i_fifo.tx_empty))
        else $error("tx empty bit wrong");
    AST_FULL: assert property (rd_r |-> o_hrdata[4] == $past(i_fifo.tx_full)
        && o_hrdata[0] == $past(i_fifo.rx_full) && o_hrdata[31:8] == 24'h0)
        else $error("full bits wrong");
    AST_IDLE: assert property (rd_r |-> o_hrdata[3] != $past(i_fifo.rx_busy))
        else $error("rx idle bit wrong");
    AST_FLOW: assert property (rd_r |-> o_hrdata[2] == $past(i_fifo.flow_ok))
        else $error("flow bit wrong");
    AST_RX_BUFFER_EMPTY: assert property (rd_r |-> o_hrdata[1] == $past(i_fifo.rx_empty))
        else $error("rx empty bit wrong");
    AST_TXFL: assert property (o_tx_flush == $past(txf))
        else $error("tx flush pulse wrong");
    AST_RXFL: assert property (o_rx_flush == $past(rxf))
        else $error("rx flush pulse wrong");
    AST_RXINT: assert property (o_rx_int_flag == $past(sel))
        else $error("rx interrupt flag timing wrong");
    AST_WERR: assert property (rd_r && werr_r |-> o_hrdata[7])
        else $error("write error not shown");
    AST_RST: assert property ($fell(i_sys_rst) |-> o_mode == UFS_MODE_NORMAL
        && o_stop_sel == 2'h0 && !o_irq && !o_tx_flush && !o_rx_flush)
        else $error("reset values wrong");
endmodule
bind ufs_top ufs_chk u_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_fifo(i_fifo),
    .i_evt(i_evt), .o_tx_flush(o_tx_flush), .o_rx_flush(o_rx_flush),
    .o_rx_int_flag(o_rx_int_flag), .o_mode(o_mode), .o_stop_sel(o_stop_sel), .o_irq(o_irq)
);

// ### tb/ufs_eng_model.sv
`timescale 1ns/1ps
module ufs_eng_model
    import ufs_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic    i_clk,
    input  wire logic    i_sys_rst,
    // Traffic and line state
    input  wire logic    i_tx_wr,
    input  wire logic    i_rx_in,
    input  wire logic    i_rx_busy,
    input  wire logic    i_flow_ok,
    input  wire logic    i_tx_flush,
    input  wire logic    i_rx_flush,
    // Levels seen by the block
    output ufs_fifo_type o_fifo
);
    logic [3:0] tx_cnt_r;
    logic [3:0] rx_cnt_r;
    // Transmitter stalled: bytes only leave by flush
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_tx_flush) tx_cnt_r <= 4'h0;
        else if (i_tx_wr && tx_cnt_r < DEPTH) tx_cnt_r <= tx_cnt_r + 4'h1;
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_rx_flush) rx_cnt_r <= 4'h0;
        else if (i_rx_in && rx_cnt_r < DEPTH) rx_cnt_r <= rx_cnt_r + 4'h1;
    end
    assign o_fifo = {tx_cnt_r == 4'h0, tx_cnt_r == DEPTH, rx_cnt_r == 4'h0,
                     rx_cnt_r == DEPTH, i_rx_busy, i_flow_ok};
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import ufs_pkg::*;
    logic         i_clk     = 1'b0;
    logic         i_sys_rst = 1'b1;
    logic         hsel      = 1'b0;
    logic         hwrite    = 1'b0;
    logic         rx_in     = 1'b0;
    logic         rx_busy   = 1'b0;
    logic         flow_ok   = 1'b1;
    logic [1:0]   htrans    = 2'h0;
    logic [7:0]   haddr     = 8'h00;
    logic [31:0]  hwdata    = 32'h0;
    ufs_evt_type  evt       = '0;
    logic [31:0]  hrdata;
    logic [31:0]  rd;
    logic         hready;
    logic         tx_flush;
    logic         rx_flush;
    logic         rx_int;
    logic         irq;
    logic [1:0]   stop_sel;
    logic [7:0]   param2;
    ufs_mode_type mode;
    ufs_fifo_type fifo;
    int           num_errors = 0;
    int           cmp_count  = 0;
    always #12.5 i_clk = ~i_clk;
    ufs_top dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
        .i_fifo(fifo), .i_evt(evt), .o_tx_flush(tx_flush), .o_rx_flush(rx_flush),
        .o_rx_int_flag(rx_int), .o_mode(mode), .o_stop_sel(stop_sel), .o_param2(param2),
        .o_irq(irq));
    ufs_eng_model eng (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tx_wr(evt.tx_wr), .i_rx_in(rx_in),
        .i_rx_busy(rx_busy), .i_flow_ok(flow_ok), .i_tx_flush(tx_flush),
        .i_rx_flush(rx_flush), .o_fifo(fifo));
    ////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            num_errors++;
            print_verdict;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    // Extra cycles cover flush, engine and status latency
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        repeat (2) @(posedge i_clk);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pulse(input logic [8:0] v);
        {rx_in, evt} <= v;
        @(posedge i_clk);
        {rx_in, evt} <= 9'h000;
        @(posedge i_clk);
    endtask
    task automatic wcase(input logic [31:0] ctl, input logic [8:0] e1, e2, input logic exp);
        bus(1'b1, UFS_ADDR_CTRL, ctl);
        pulse(e1);
        pulse(e2);
        chk("mode", {30'h0, ctl[1:0]}, {30'h0, mode});
        chk("param2", {24'h0, ctl[15:8]}, {24'h0, param2});
        bus(1'b0, UFS_ADDR_STATUS, 32'h0);
        chk("write error", {31'h0, exp}, {31'h0, rd[7]});
        bus(1'b1, UFS_ADDR_STATUS, 32'h20);
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        rchk("status", UFS_ADDR_STATUS, {24'h0, UFS_STATUS_RST});
        rchk("ctrl", UFS_ADDR_CTRL, 32'h0);
        rchk("irq status", UFS_ADDR_IRQST, 32'h0);
        bus(1'b1, 8'h10, 32'hffffffff);
        rchk("unmapped", 8'h10, 32'h0);
    endtask
    task automatic t_fifo;
        pulse(9'h080);
        pulse(9'h080);
        pulse(9'h100);
        pulse(9'h100);
        rchk("both full", UFS_ADDR_STATUS, 32'h1d);
        pulse(9'h080);
        rchk("write on full", UFS_ADDR_STATUS, 32'h9d);
        bus(1'b1, UFS_ADDR_STATUS, 32'h80);
        rchk("zero writes", UFS_ADDR_STATUS, 32'h9d);
        bus(1'b1, UFS_ADDR_STATUS, 32'h02);
        rchk("rx flush", UFS_ADDR_STATUS, 32'h1e);
        bus(1'b1, UFS_ADDR_STATUS, 32'h20);
        rchk("tx flush", UFS_ADDR_STATUS, 32'h2e);
        flow_ok <= 1'b0;
        rx_busy <= 1'b1;
        bus(1'b1, UFS_ADDR_STATUS, 32'h1d);
        rchk("line busy", UFS_ADDR_STATUS, 32'h22);
        flow_ok <= 1'b1;
        rx_busy <= 1'b0;
    endtask
    task automatic t_werr;
        wcase(32'h1, 9'h048, 9'h000, 1'b1);
        wcase(32'h1, 9'h040, 9'h000, 1'b0);
        wcase(32'h2, 9'h080, 9'h000, 1'b1);
        wcase(32'h102, 9'h020, 9'h080, 1'b0);
        wcase(32'h102, 9'h080, 9'h080, 1'b1);
        wcase(32'h3, 9'h010, 9'h040, 1'b0);
        wcase(32'h3, 9'h040, 9'h040, 1'b1);
        wcase(32'h0, 9'h048, 9'h048, 1'b0);
    endtask
    task automatic t_stop;
        logic exp;
        chk("irq masked", 32'h0, {31'h0, irq});
        for (int t = 0; t < 2; t++) begin
            for (int s = 0; s < 4; s += 3) begin
                bus(1'b1, UFS_ADDR_STATUS, 32'(t << 6));
                bus(1'b1, UFS_ADDR_CTRL, 32'(s << 2));
                for (int k = 0; k < 3; k++) begin
                    pulse(9'h004 >> k);
                    exp = (t == 1) ? ((s == 3) ? k == 1 : k == 2) : k == 0;
                    chk("rx int", {31'h0, exp}, {31'h0, rx_int});
                end
                chk("stop sel", 32'(s), {30'h0, stop_sel});
            end
        end
        bus(1'b1, UFS_ADDR_IRQMSK, 32'h2);
        @(posedge i_clk);
        chk("irq on", 32'h1, {31'h0, irq});
        rchk("irq status", UFS_ADDR_IRQST, 32'h7);
        bus(1'b1, UFS_ADDR_IRQST, 32'h7);
        @(posedge i_clk);
        chk("irq off", 32'h0, {31'h0, irq});
        rchk("irq cleared", UFS_ADDR_IRQST, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        t_reset;
        t_fifo;
        t_werr;
        t_stop;
        print_verdict;
    end
endmodule
